// >>> hw/wpt_tx_config_negotiation.sv
// transmitter config-phase timing, contract and negotiation engine
//
// Operation
// - wait 22..25 ms for next header
// - packet must finish within 170 ms
// - reply starts 3 to 10 ms after request
// - hold-off 5..205 ms, default 5 ms
// - foreign object build initial contract at config end
// - copy contract to temporary before negotiation
// - exactly one reply per request
// - remove power 200 ms after last reply
// - unknown packet type removes power, back selection
// - errored packet discarded, no reply, stay
// - reserved code or bit gives not defined
// - guaranteed power: update and ACK if supported
// - received power format: ACK only for 0x31
// - FSK request updates polarity, depth, ACK
// - maximum power request updates, ACK unless reserved bit set
// - without extensions keep maximum power in contract
// - negotiation flag: ACK then negotiate, else transfer
// - coil current off within 28 ms
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module wpt_tx_config_negotiation #(
  parameter int unsigned CYC_PER_MS = wpt_cfg_pkg::CYC_PER_MS
) (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // packets from the demodulator
  input  wire logic                   rx_start,
  input  wire logic                   rx_done,
  input  wire logic                   rx_err,
  input  wire wpt_cfg_pkg::rx_pkt_t   rx_pkt,
  // response to the modulator
  output logic                        resp_valid,
  output wpt_cfg_pkg::resp_t          resp_kind,
  input  wire logic                   resp_ready,
  // power stage and interrupt
  output logic                        power_on,
  output logic                        irq
);
  typedef enum logic [2:0] {
    ST_SELECT, ST_CONFIG, ST_RESP, ST_NEGOTIATE, ST_TRANSFER
  } state_t;

  localparam int unsigned N_EVT      = wpt_cfg_pkg::N_EVT;
  localparam int unsigned NEG_BIT    = wpt_cfg_pkg::NEG_BIT;
  localparam int unsigned CNT_LSB    = wpt_cfg_pkg::CNT_LSB;
  localparam int unsigned POL_BIT    = wpt_cfg_pkg::POL_BIT;
  localparam int unsigned DEPTH_LSB  = wpt_cfg_pkg::DEPTH_LSB;
  localparam logic [7:0]  NEXT_TICKS = wpt_cfg_pkg::NEXT_TICKS;
  localparam logic [7:0]  MAX_TICKS  = wpt_cfg_pkg::MAX_TICKS;
  localparam logic [7:0]  NEG_TICKS  = wpt_cfg_pkg::NEG_TICKS;

  state_t                 state_reg;
  logic [17:0]            div_reg;
  logic                   tick;
  logic [7:0]             ms_reg;
  logic                   in_pkt_reg;
  logic [2:0]             opt_reg;
  logic [1:0]             seq_reg;
  logic [7:0]             delay_reg;
  logic                   fod_reg;
  logic [5:0]             gplim_reg;
  logic [N_EVT-1:0]       irq_reg;
  logic [N_EVT-1:0]       mask_reg;
  logic [N_EVT-1:0]       evt;
  wpt_cfg_pkg::contract_t active_reg;
  wpt_cfg_pkg::contract_t temp_reg;
  wpt_cfg_pkg::resp_t     kind_reg;
  logic                   go;
  logic                   restart;
  logic                   remove;
  logic                   to_neg;
  logic                   to_xfer;
  logic                   to_resp;
  logic                   discard;
  logic                   sent;
  logic                   wr_acc;
  logic                   rd_acc;
  logic                   rd_setup;
  logic                   mapped;
  logic [31:0]            rd_mux;

  // millisecond tick; divider restarts with the timer for exact spacing
  assign tick = (div_reg == 18'(CYC_PER_MS - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 18'h00000;
    end else if (restart || tick) begin
      div_reg <= 18'h00000;
    end else begin
      div_reg <= div_reg + 18'h00001;
    end
  end

  // one ms counter serves every phase timeout, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_reg <= 8'h00;
    end else if (restart) begin
      ms_reg <= 8'h00;
    end else if (tick && ms_reg != 8'hff) begin
      ms_reg <= ms_reg + 8'h01;
    end
  end

  // packet classification
  logic       hdr_req;
  logic       cfg_cnt_ok;
  logic       delay_ok;
  logic [7:0] req_code;
  logic [7:0] req_val;
  logic       cfg_neg;
  assign req_code = rx_pkt.data[7:0];
  assign req_val  = rx_pkt.data[15:8];
  assign cfg_neg  = rx_pkt.data[NEG_BIT];
  assign hdr_req  = (rx_pkt.hdr == wpt_cfg_pkg::HDR_SPEC)
                 || (rx_pkt.hdr == wpt_cfg_pkg::HDR_GEN)
                 || (rx_pkt.hdr == wpt_cfg_pkg::HDR_STATUS)
                 || (rx_pkt.hdr == wpt_cfg_pkg::HDR_IDENT)
                 || (rx_pkt.hdr >= wpt_cfg_pkg::HDR_PROP_LO
                     && rx_pkt.hdr <= wpt_cfg_pkg::HDR_PROP_HI)
                 || (rx_pkt.hdr >= wpt_cfg_pkg::HDR_RSV_LO);
  assign cfg_cnt_ok = (rx_pkt.data[CNT_LSB +: 3] == opt_reg);
  assign delay_ok   = (delay_reg >= wpt_cfg_pkg::DELAY_MIN)
                   && (delay_reg <= wpt_cfg_pkg::DELAY_MAX);

  // config-phase decisions on a correctly received packet
  logic cfg_done;
  logic cfg_bad;
  always_comb begin
    cfg_done = 1'b0;
    cfg_bad  = 1'b0;
    if (state_reg == ST_CONFIG && rx_done) begin
      if (seq_reg == 2'd0) begin
        cfg_bad = (rx_pkt.hdr != wpt_cfg_pkg::HDR_IDENT);
      end else if (seq_reg == 2'd1) begin
        cfg_bad = (rx_pkt.hdr != wpt_cfg_pkg::HDR_EXT_ID);
      end else if (rx_pkt.hdr == wpt_cfg_pkg::HDR_CONFIG) begin
        cfg_done = cfg_cnt_ok && delay_ok;
        cfg_bad  = !(cfg_cnt_ok && delay_ok);
      end else begin
        cfg_bad = (opt_reg == 3'(wpt_cfg_pkg::MAX_OPT));
      end
    end
  end

  // reply chosen for a negotiation request
  wpt_cfg_pkg::resp_t neg_kind;
  always_comb begin
    neg_kind = wpt_cfg_pkg::RESP_ND;
    if (rx_pkt.hdr == wpt_cfg_pkg::HDR_SPEC) begin
      case (req_code)
        wpt_cfg_pkg::REQ_GPWR: begin
          if ((req_val & wpt_cfg_pkg::PWR_RSV) != 8'h00) begin
            neg_kind = wpt_cfg_pkg::RESP_ND;
          end else if (req_val[5:0] <= gplim_reg) begin
            neg_kind = wpt_cfg_pkg::RESP_ACK;
          end else begin
            neg_kind = wpt_cfg_pkg::RESP_NAK;
          end
        end
        wpt_cfg_pkg::REQ_RPT: begin
          neg_kind = (req_val == wpt_cfg_pkg::HDR_RP24)
                   ? wpt_cfg_pkg::RESP_ACK
                   : wpt_cfg_pkg::RESP_NAK;
        end
        wpt_cfg_pkg::REQ_FSK: begin
          neg_kind = ((req_val & wpt_cfg_pkg::FSK_RSV) != 8'h00)
                   ? wpt_cfg_pkg::RESP_ND
                   : wpt_cfg_pkg::RESP_ACK;
        end
        wpt_cfg_pkg::REQ_MAXP: begin
          neg_kind = ((req_val & wpt_cfg_pkg::PWR_RSV) != 8'h00)
                   ? wpt_cfg_pkg::RESP_ND
                   : wpt_cfg_pkg::RESP_ACK;
        end
        default: begin
          // reserved codes and end request
          neg_kind = wpt_cfg_pkg::RESP_ND;
        end
      endcase
    end
  end

  // phase transitions and timeouts
  always_comb begin
    remove  = 1'b0;
    to_neg  = 1'b0;
    to_xfer = 1'b0;
    to_resp = 1'b0;
    discard = 1'b0;
    case (state_reg)
      ST_CONFIG: begin
        if (rx_err || cfg_bad) begin
          remove = 1'b1;
        end else if (!in_pkt_reg && !rx_start && ms_reg >= NEXT_TICKS) begin
          remove = 1'b1;
        end else if (in_pkt_reg && !rx_done && ms_reg >= MAX_TICKS) begin
          remove = 1'b1;
        end else if (cfg_done) begin
          if (fod_reg && cfg_neg) begin
            to_resp = 1'b1;
          end else begin
            to_xfer = 1'b1;
          end
        end
      end
      ST_RESP: begin
        if (sent) begin
          to_neg = 1'b1;
        end
      end
      ST_NEGOTIATE: begin
        if (rx_err) begin
          discard = 1'b1;
        end else if (rx_done && !hdr_req) begin
          remove = 1'b1;
        end else if (rx_done) begin
          to_resp = 1'b1;
        end else if (!in_pkt_reg && !rx_start && ms_reg >= NEG_TICKS) begin
          remove = 1'b1;
        end else if (in_pkt_reg && ms_reg >= MAX_TICKS) begin
          discard = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  assign sent    = resp_valid && resp_ready;
  assign restart = go || rx_start || rx_done || rx_err || sent || to_resp;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_SELECT;
    end else if (remove) begin
      state_reg <= ST_SELECT;
    end else if (to_resp) begin
      state_reg <= ST_RESP;
    end else if (to_neg) begin
      state_reg <= ST_NEGOTIATE;
    end else if (to_xfer) begin
      state_reg <= ST_TRANSFER;
    end else if (go) begin
      state_reg <= ST_CONFIG;
    end
  end

  // packet framing and config sequence tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_pkt_reg <= 1'b0;
    end else if (rx_start) begin
      in_pkt_reg <= 1'b1;
    end else if (rx_done || rx_err || discard || remove) begin
      in_pkt_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg   <= 2'd0;
      opt_reg   <= 3'd0;
      delay_reg <= wpt_cfg_pkg::DELAY_MIN;
    end else if (go) begin
      seq_reg   <= 2'd0;
      opt_reg   <= 3'd0;
      delay_reg <= wpt_cfg_pkg::DELAY_MIN;
    end else if (state_reg == ST_CONFIG && rx_done && !cfg_bad) begin
      if (seq_reg == 2'd0) begin
        seq_reg <= rx_pkt.data[wpt_cfg_pkg::EXT_BIT] ? 2'd1 : 2'd2;
      end else if (seq_reg == 2'd1) begin
        seq_reg <= 2'd2;
      end else if (rx_pkt.hdr != wpt_cfg_pkg::HDR_CONFIG) begin
        opt_reg <= opt_reg + 3'd1;
        if (rx_pkt.hdr == wpt_cfg_pkg::HDR_HOLDOFF) begin
          delay_reg <= rx_pkt.data[7:0];
        end
      end
    end
  end

  // contracts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg <= '0;
    end else if (cfg_done && fod_reg) begin
      active_reg.gpwr  <= wpt_cfg_pkg::GPWR_INIT;
      active_reg.maxp  <= rx_pkt.data[5:0];
      active_reg.rpfmt <= wpt_cfg_pkg::HDR_RP8;
      active_reg.pol   <= rx_pkt.data[POL_BIT];
      active_reg.depth <= rx_pkt.data[DEPTH_LSB +: 2];
    end else if (cfg_done) begin
      active_reg      <= '0;
      active_reg.maxp <= rx_pkt.data[5:0];
    end
  end

  // only the temporary copy changes while negotiating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_reg <= '0;
    end else if (cfg_done && fod_reg) begin
      temp_reg.gpwr  <= wpt_cfg_pkg::GPWR_INIT;
      temp_reg.maxp  <= rx_pkt.data[5:0];
      temp_reg.rpfmt <= wpt_cfg_pkg::HDR_RP8;
      temp_reg.pol   <= rx_pkt.data[POL_BIT];
      temp_reg.depth <= rx_pkt.data[DEPTH_LSB +: 2];
    end else if (state_reg == ST_NEGOTIATE && to_resp
                 && rx_pkt.hdr == wpt_cfg_pkg::HDR_SPEC
                 && neg_kind == wpt_cfg_pkg::RESP_ACK) begin
      case (req_code)
        wpt_cfg_pkg::REQ_GPWR: temp_reg.gpwr  <= req_val[5:0];
        wpt_cfg_pkg::REQ_RPT:  temp_reg.rpfmt <= req_val;
        wpt_cfg_pkg::REQ_FSK: begin
          temp_reg.pol   <= req_val[2];
          temp_reg.depth <= req_val[1:0];
        end
        wpt_cfg_pkg::REQ_MAXP: temp_reg.maxp <= req_val[5:0];
        default: begin
        end
      endcase
    end
  end

  // reply held back for the minimum response time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_reg <= wpt_cfg_pkg::RESP_ACK;
    end else if (to_resp && state_reg == ST_CONFIG) begin
      kind_reg <= wpt_cfg_pkg::RESP_ACK;
    end else if (to_resp) begin
      kind_reg <= neg_kind;
    end
  end

  // modulator owns the 10 ms upper bound
  assign resp_valid = (state_reg == ST_RESP)
                   && (ms_reg >= wpt_cfg_pkg::RESP_TICKS);
  assign resp_kind  = kind_reg;
  assign power_on   = (state_reg != ST_SELECT);

  // apb slave, zero wait states
  assign pready   = 1'b1;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign go       = wr_acc && paddr == wpt_cfg_pkg::A_CTRL
                 && pwdata[wpt_cfg_pkg::CTRL_GO]
                 && state_reg == ST_SELECT;
  assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= wpt_cfg_pkg::A_GPLIM);
  assign pslverr  = psel && penable && !mapped;

  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      wpt_cfg_pkg::A_CTRL: begin
        rd_mux[wpt_cfg_pkg::CTRL_FOD] = fod_reg;
      end
      wpt_cfg_pkg::A_STATUS: begin
        rd_mux = {24'h000000, opt_reg, in_pkt_reg, 1'b0, state_reg};
      end
      wpt_cfg_pkg::A_IRQ:     rd_mux = {27'h0000000, irq_reg};
      wpt_cfg_pkg::A_MASK:    rd_mux = {27'h0000000, mask_reg};
      wpt_cfg_pkg::A_ACTIVE:  rd_mux = {9'h000, active_reg};
      wpt_cfg_pkg::A_TEMP:    rd_mux = {9'h000, temp_reg};
      wpt_cfg_pkg::A_HOLDOFF: rd_mux = {24'h000000, delay_reg};
      wpt_cfg_pkg::A_GPLIM:   rd_mux = {26'h0000000, gplim_reg};
      default:                rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fod_reg   <= 1'b0;
      mask_reg  <= '0;
      gplim_reg <= wpt_cfg_pkg::GPLIM_RST;
    end else if (wr_acc) begin
      case (paddr)
        wpt_cfg_pkg::A_CTRL:  fod_reg   <= pwdata[wpt_cfg_pkg::CTRL_FOD];
        wpt_cfg_pkg::A_MASK:  mask_reg  <= pwdata[N_EVT-1:0];
        wpt_cfg_pkg::A_GPLIM: gplim_reg <= pwdata[5:0];
        default: begin
        end
      endcase
    end
  end

  // events: removal, negotiation entry, transfer entry, reply, discard
  assign evt = {discard, sent, to_xfer, to_neg, remove};

  // read clears, but a same-cycle event still sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= '0;
    end else if (rd_acc && paddr == wpt_cfg_pkg::A_IRQ) begin
      irq_reg <= evt;
    end else begin
      irq_reg <= irq_reg | evt;
    end
  end

  assign irq = |(irq_reg & mask_reg);
endmodule

// >>> pkg/wpt_cfg_pkg.sv
// shared constants and types for the transmitter configuration/negotiation
package wpt_cfg_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / MS_PER_S;
  localparam int unsigned T_NEXT_MIN_MS  = 22;
  localparam int unsigned T_NEXT_MAX_MS  = 25;
  localparam int unsigned T_MAX_MS       = 170;
  localparam int unsigned T_RESP_MIN_MS  = 3;
  localparam int unsigned T_RESP_MAX_MS  = 10;
  localparam int unsigned T_NEG_MIN_MS   = 200;
  localparam int unsigned T_TERM_MAX_MS  = 28;
  localparam int unsigned T_DELAY_MIN_MS = 5;
  localparam int unsigned T_DELAY_MAX_MS = 205;
  // tick jitter is under one ms, so one extra tick keeps each minimum
  localparam logic [7:0] NEXT_TICKS  = 8'(T_NEXT_MIN_MS + 1);
  localparam logic [7:0] MAX_TICKS   = 8'(T_MAX_MS);
  localparam logic [7:0] RESP_TICKS  = 8'(T_RESP_MIN_MS + 1);
  localparam logic [7:0] NEG_TICKS   = 8'(T_NEG_MIN_MS + 1);
  localparam logic [7:0] DELAY_MIN   = 8'(T_DELAY_MIN_MS);
  localparam logic [7:0] DELAY_MAX   = 8'(T_DELAY_MAX_MS);
  // packet headers
  localparam logic [7:0] HDR_IDENT   = 8'h71;
  localparam logic [7:0] HDR_EXT_ID  = 8'h81;
  localparam logic [7:0] HDR_HOLDOFF = 8'h06;
  localparam logic [7:0] HDR_CONFIG  = 8'h51;
  localparam logic [7:0] HDR_SPEC    = 8'h20;
  localparam logic [7:0] HDR_GEN     = 8'h07;
  localparam logic [7:0] HDR_STATUS  = 8'h22;
  localparam logic [7:0] HDR_RP8     = 8'h04;
  localparam logic [7:0] HDR_RP24    = 8'h31;
  localparam logic [7:0] HDR_PROP_LO = 8'h18;
  localparam logic [7:0] HDR_PROP_HI = 8'h1f;
  localparam logic [7:0] HDR_RSV_LO  = 8'h90;
  localparam logic [7:0] HDR_RSV_HI  = 8'hff;
  // specific request codes
  localparam logic [7:0] REQ_END  = 8'h00;
  localparam logic [7:0] REQ_GPWR = 8'h01;
  localparam logic [7:0] REQ_RPT  = 8'h02;
  localparam logic [7:0] REQ_FSK  = 8'h03;
  localparam logic [7:0] REQ_MAXP = 8'h04;
  // field layout of packet payload bytes
  localparam int unsigned EXT_BIT   = 7;
  localparam int unsigned NEG_BIT   = 23;
  localparam int unsigned POL_BIT   = 22;
  localparam int unsigned DEPTH_LSB = 20;
  localparam int unsigned CNT_LSB   = 8;
  localparam int unsigned MAX_OPT   = 7;
  localparam logic [5:0]  GPWR_INIT = 6'h0a;
  localparam logic [7:0]  PWR_RSV   = 8'hc0;
  localparam logic [7:0]  FSK_RSV   = 8'hf8;
  // register byte addresses
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_IRQ     = 8'h08;
  localparam logic [7:0] A_MASK    = 8'h0c;
  localparam logic [7:0] A_ACTIVE  = 8'h10;
  localparam logic [7:0] A_TEMP    = 8'h14;
  localparam logic [7:0] A_HOLDOFF = 8'h18;
  localparam logic [7:0] A_GPLIM   = 8'h1c;
  localparam int unsigned CTRL_GO  = 0;
  localparam int unsigned CTRL_FOD = 1;
  localparam int unsigned N_EVT    = 5;
  localparam logic [5:0]  GPLIM_RST = 6'h0a;

  typedef enum logic [1:0] {RESP_ACK, RESP_NAK, RESP_ND, RESP_DATA} resp_t;
  typedef struct packed {
    logic [7:0]  hdr;
    logic [31:0] data;
  } rx_pkt_t;
  typedef struct packed {
    logic [5:0] gpwr;
    logic [5:0] maxp;
    logic [7:0] rpfmt;
    logic       pol;
    logic [1:0] depth;
  } contract_t;
endpackage

// >>> sim/rx_ctl_model.sv
// receiver controller model: sends packets, takes replies
`timescale 1ns/10ps
module rx_ctl_model (
  // clock
  input  wire logic               pclk,
  // packets to the transmitter
  output logic                    rx_start,
  output logic                    rx_done,
  output logic                    rx_err,
  output wpt_cfg_pkg::rx_pkt_t    rx_pkt,
  // replies
  input  wire logic               resp_valid,
  input  wire wpt_cfg_pkg::resp_t resp_kind,
  output logic                    resp_ready
);
  int unsigned        ready_lag = 0;
  int unsigned        n_resp = 0;
  int unsigned        lag_cnt = 0;
  wpt_cfg_pkg::resp_t last_kind;
  initial {rx_start, rx_done, rx_err, rx_pkt, resp_ready} = '0;
  // mode 0 good, 1 corrupted, 2 start bit only
  task automatic send(input logic [7:0] h, input logic [31:0] d, input int m);
    @(posedge pclk);
    rx_start <= 1'b1;
    @(posedge pclk);
    rx_start <= 1'b0;
    if (m != 2) begin
      repeat (20) @(posedge pclk);
      rx_pkt <= '{h, d};
      rx_done <= (m == 0);
      rx_err <= (m == 1);
      @(posedge pclk);
      rx_done <= 1'b0;
      rx_err <= 1'b0;
      rx_pkt <= ~rx_pkt; // scrambled after the strobe
    end
  endtask
  // settable accept lag
  always @(posedge pclk) begin
    if (resp_valid && resp_ready) begin
      last_kind <= resp_kind;
      n_resp <= n_resp + 1;
      resp_ready <= 1'b0;
      lag_cnt <= 0;
    end else if (resp_valid) begin
      lag_cnt <= lag_cnt + 1;
      if (lag_cnt >= ready_lag) resp_ready <= 1'b1;
    end
  end
endmodule

// >>> sim/wpt_tx_config_negotiation_tb.sv
// self-checking bench for the config and negotiation block
`timescale 1ns/10ps
module wpt_tx_config_negotiation_tb;
  localparam int unsigned CPM = 10;
  typedef struct {
    logic [7:0]  hdr;
    logic [31:0] data;
    logic [1:0]  kind;
  } row_t;
  // kind 0 ack, 1 nak, 2 not defined
  row_t rows [14] = '{
    '{8'h20, 32'h0801, 2'h0}, '{8'h20, 32'h0b01, 2'h1},
    '{8'h20, 32'h4801, 2'h2}, '{8'h20, 32'h3102, 2'h0},
    '{8'h20, 32'h0402, 2'h1}, '{8'h20, 32'h0503, 2'h0},
    '{8'h20, 32'h0d03, 2'h2}, '{8'h20, 32'h2004, 2'h0},
    '{8'h20, 32'h8004, 2'h2}, '{8'h20, 32'h0005, 2'h2},
    '{8'h07, 32'h0, 2'h2}, '{8'h22, 32'h0, 2'h2},
    '{8'h18, 32'h0, 2'h2}, '{8'h90, 32'h0, 2'h2}};
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata, rd;
  logic                   pready, pslverr, slv, rx_start, rx_done, rx_err;
  logic                   resp_valid, resp_ready, power_on, irq;
  wpt_cfg_pkg::rx_pkt_t   rx_pkt;
  wpt_cfg_pkg::resp_t     resp_kind, k;
  wpt_cfg_pkg::contract_t exp_c;
  int unsigned            err_count = 0, checked = 0, n0;
  logic [31:0]            hold [2] = '{32'h04, 32'hce};

  wpt_tx_config_negotiation #(.CYC_PER_MS(CPM))
    wpt_tx_config_negotiation_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_start,
    .rx_done, .rx_err, .rx_pkt, .resp_valid, .resp_kind, .resp_ready,
    .power_on, .irq);
  rx_ctl_model rx_ctl_model_inst (.pclk, .rx_start, .rx_done, .rx_err,
    .rx_pkt, .resp_valid, .resp_kind, .resp_ready);

  always #2 pclk = ~pclk;

  task automatic chk(input string n, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int unsigned n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) err_count++;
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic start();
    apb(1'b1, wpt_cfg_pkg::A_CTRL, 32'h3);
  endtask
  task automatic ms(input int unsigned n);
    repeat (n * CPM) @(posedge pclk);
    #1;
  endtask
  task automatic pkt(input logic [7:0] h, input logic [31:0] d);
    rx_ctl_model_inst.send(h, d, 0);
    #1;
  endtask
  task automatic reply();
    int unsigned i = 0;
    n0 = rx_ctl_model_inst.n_resp;
    while (rx_ctl_model_inst.n_resp == n0 && i < 400) begin
      @(posedge pclk);
      i++;
    end
    if (i == 400) err_count++;
    k = rx_ctl_model_inst.last_kind;
  endtask
  task automatic reset_dut();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("reset power", power_on, 1'b0);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdr(wpt_cfg_pkg::A_GPLIM);
    chk("gplim reset", rd, 32'h0a);
    rdr(8'h20);
    chk("unmapped err", slv, 1'b1);
    chk("unmapped rd", rd, 32'h0);
    apb(1'b1, wpt_cfg_pkg::A_MASK, 32'h1f);
    start();
    pkt(8'h71, 32'h0);
    pkt(8'h06, 32'h0a);
    pkt(8'h51, 32'h00e00114);
    reply();
    chk("config reply", k, wpt_cfg_pkg::RESP_ACK);
    rdr(wpt_cfg_pkg::A_HOLDOFF);
    chk("holdoff", rd, 32'h0a);
    exp_c = '{6'h0a, 6'h14, 8'h04, 1'b1, 2'h2};
    rdr(wpt_cfg_pkg::A_ACTIVE);
    chk("active init", rd, 32'(exp_c));
    rdr(wpt_cfg_pkg::A_TEMP);
    chk("temp copy", rd, 32'(exp_c));
    chk("irq raised", irq, 1'b1);
    rdr(wpt_cfg_pkg::A_IRQ);
    chk("irq status", rd, 32'h0a);
    chk("irq cleared", irq, 1'b0);
    apb(1'b1, wpt_cfg_pkg::A_MASK, 32'h0);
    foreach (rows[i]) begin
      rx_ctl_model_inst.ready_lag = (i % 2) * 15;
      pkt(rows[i].hdr, rows[i].data);
      reply();
      chk("reply", k, rows[i].kind);
    end
    chk("irq masked", irq, 1'b0);
    apb(1'b1, wpt_cfg_pkg::A_MASK, 32'h08);
    chk("irq unmasked", irq, 1'b1);
    rdr(wpt_cfg_pkg::A_TEMP);
    chk("temp updated", rd, 32'h11018d);
    rdr(wpt_cfg_pkg::A_ACTIVE);
    chk("active kept", rd, 32'(exp_c));
    rx_ctl_model_inst.send(8'h20, 32'h0801, 1);
    ms(12);
    chk("bad pkt reply", rx_ctl_model_inst.n_resp, n0 + 1);
    rdr(wpt_cfg_pkg::A_STATUS);
    chk("bad pkt state", rd[2:0], 3'h3);
    pkt(8'h51, 32'h0);
    chk("foreign type", power_on, 1'b0);
    start();
    pkt(8'h71, 32'h0);
    pkt(8'h51, 32'h00800000);
    reply();
    rdr(wpt_cfg_pkg::A_HOLDOFF);
    chk("holdoff dflt", rd, 32'h05);
    ms(194);
    chk("neg idle on", power_on, 1'b1);
    ms(9);
    chk("neg idle off", power_on, 1'b0);
    rdr(wpt_cfg_pkg::A_IRQ);
    chk("removal event", rd[0], 1'b1);
    start();
    pkt(8'h71, 32'h0);
    ms(21);
    chk("next wait on", power_on, 1'b1);
    ms(4);
    chk("next wait off", power_on, 1'b0);
    start();
    rx_ctl_model_inst.send(8'h71, 32'h0, 2);
    ms(165);
    chk("long pkt on", power_on, 1'b1);
    ms(7);
    chk("long pkt off", power_on, 1'b0);
    foreach (hold[j]) begin
      start();
      pkt(8'h71, 32'h0);
      pkt(8'h06, hold[j]);
      pkt(8'h51, 32'h00800100);
      chk("holdoff range", power_on, 1'b0);
    end
    for (int j = 0; j < 2; j++) begin
      reset_dut();
      apb(1'b1, wpt_cfg_pkg::A_CTRL, j ? 32'h3 : 32'h1);
      pkt(8'h71, 32'h0);
      n0 = rx_ctl_model_inst.n_resp;
      pkt(8'h51, j ? 32'h00000014 : 32'h00800014);
      ms(12);
      chk("silent transfer", rx_ctl_model_inst.n_resp, n0);
      rdr(wpt_cfg_pkg::A_STATUS);
      chk("transfer state", rd[2:0], 3'h4);
      rdr(wpt_cfg_pkg::A_ACTIVE);
      chk("max power kept", rd[16:11], 6'h14);
    end
    summarize();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    summarize();
  end
endmodule

// >>> sim/wpt_tx_sva.sv
// assertion checker for the config and negotiation block
`timescale 1ns/10ps
module wpt_tx_sva #(
  parameter int unsigned CYC_PER_MS = 10
) (
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // apb
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // link
  input wire logic               rx_done,
  input wire logic               resp_valid,
  input wire wpt_cfg_pkg::resp_t resp_kind,
  input wire logic               resp_ready,
  input wire logic               power_on
);
  localparam int unsigned MIN_C = 3 * CYC_PER_MS;
  localparam int unsigned MAX_C = 10 * CYC_PER_MS;
  logic [31:0] since_done;
  wire         acc = psel && penable;
  wire         bad = paddr > 8'h1c || paddr[1:0] != 2'h0;
  // saturates so an old request never looks fresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_done <= '1;
    else if (rx_done) since_done <= 32'h1;
    else if (since_done != '1) since_done <= since_done + 32'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_resp_window: assert property ($rose(resp_valid) |->
    since_done >= MIN_C && since_done <= MAX_C) else $error("reply timing");
  a_resp_holds: assert property (resp_valid && !resp_ready
    |=> resp_valid && $stable(resp_kind)) else $error("reply dropped");
  a_reply_once: assert property (resp_valid && resp_ready
    |=> !resp_valid) else $error("reply repeated");
  a_resp_powered: assert property (resp_valid |-> power_on)
    else $error("reply without power");
  a_power_by_go: assert property ($rose(power_on) |->
    $past(acc && pwrite && paddr == 8'h00 && pwdata[0])) else $error("power");
  a_unmapped_err: assert property (acc && bad |->
    pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access");
  a_mapped_ok: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access refused");
  a_pready_high: assert property (pready) else $error("wait state");
  c_ack: cover property (resp_valid && resp_ready && resp_kind == 2'h0);
  c_nd: cover property (resp_valid && resp_ready && resp_kind == 2'h2);
  c_off: cover property ($fell(power_on));
endmodule

bind wpt_tx_config_negotiation wpt_tx_sva #(.CYC_PER_MS(CYC_PER_MS))
  wpt_tx_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .rx_done, .resp_valid, .resp_kind,
  .resp_ready, .power_on);
